// ==== verilog/dcs_defs.vh ====
// constants for the diagnostic setup and fault status message block
// Behaviour
// - selector 0000010 in bits 30:24 picks setup word channels 0-3; bit 31 writes.
// - selector 0000011 picks setup word channels 4-7, same layout and read/write bit.
// - two-bit battery short threshold per channel, 0.7 to 1.3 volts, reset 11.
// - four-bit retry field per channel, sixteen times value PWM periods, reset 1111.
// - setup answer echoes selector plus all four channels' threshold and retry fields.
// - status words treat a write as a read and leave the setup store unchanged.
// - selector 0000100 picks status word channels 0-3, echoed in bits 30:24.
// - selector 0000101 picks status word channels 4-7 with the same layout.
// - ground short flag per channel at bits 23,17,11,5, zero after reset.
// - gate-off test done flag at bits 22,16,10,4, zero after reset.
// - battery short fault flag at bits 21,15,9,3, zero after reset.
// - battery short test done flag at bits 20,14,8,2, zero after reset.
// - open load gate-off flag at bits 19,13,7,1, zero after reset.
// - open load gate-on flag at bits 18,12,6,0, zero after reset.
// - per-channel mask decides whether its faults raise the fault pin; reset off.
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

// ==========================================================
// frame layout
`define DCS_FRAME_BITS   6'h20
`define DCS_RW_BIT       31
`define DCS_ID_HI        30
`define DCS_ID_LO        24
`define DCS_DATA_HI      23
`define DCS_CH_W         6

// ==========================================================
// message selectors
`define DCS_ID_CFG_LO    7'h02
`define DCS_ID_CFG_HI    7'h03
`define DCS_ID_STS_LO    7'h04
`define DCS_ID_STS_HI    7'h05

// ==========================================================
// reset values
`define DCS_LVL_RST      2'h3
`define DCS_RETRY_RST    4'hF
`define DCS_CFG_RST      48'hFFFFFFFFFFFF
`define DCS_STS_RST      48'h000000000000
`define DCS_SYNC_RST     3'h2

// ==========================================================
// status flag positions inside one channel field
`define DCS_F_GND        5
`define DCS_F_OFFT       4
`define DCS_F_BAT        3
`define DCS_F_SBT        2
`define DCS_F_OLOF       1
`define DCS_F_OLON       0

`endif

// ==== verilog/dcs_sync.v ====
// two-flop synchroniser for the serial pins
`include "dcs_defs.vh"

module dcs_sync (
   input  wire       clock,
   input  wire       rst,
   input  wire [2:0] d,
   output reg  [2:0] q
);

   reg [2:0] meta_r;

   // ==========================================================
   // first stage feeds only the second
   always @(posedge clock) begin
      if (rst) begin
         meta_r <= `DCS_SYNC_RST;
         q      <= `DCS_SYNC_RST;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

// ==== verilog/dcs_status.v ====
// sticky per-channel fault and test-done flags
`include "dcs_defs.vh"

module dcs_status (
   input  wire        clock,
   input  wire        rst,
   input  wire [7:0]  ground_short_evt,
   input  wire [7:0]  gate_off_test_evt,
   input  wire [7:0]  battery_short_evt,
   input  wire [7:0]  battery_short_test_evt,
   input  wire [7:0]  open_load_gate_off_evt,
   input  wire [7:0]  open_load_gate_on_evt,
   input  wire        clear_low,
   input  wire        clear_high,
   output reg  [47:0] flags_r
);

   reg     [47:0] set_v;
   reg     [47:0] clr_v;
   integer        c;

   // ==========================================================
   // gather events into six-bit channel fields
   always @* begin
      set_v = 48'h000000000000;
      clr_v = 48'h000000000000;
      for (c = 0; c < 8; c = c + 1) begin
         set_v[6 * c + `DCS_F_GND]  = ground_short_evt[c];
         set_v[6 * c + `DCS_F_OFFT] = gate_off_test_evt[c];
         set_v[6 * c + `DCS_F_BAT]  = battery_short_evt[c];
         set_v[6 * c + `DCS_F_SBT]  = battery_short_test_evt[c];
         set_v[6 * c + `DCS_F_OLOF] = open_load_gate_off_evt[c];
         set_v[6 * c + `DCS_F_OLON] = open_load_gate_on_evt[c];
         clr_v[6 * c +: 6] = (c < 4) ? {6{clear_low}} : {6{clear_high}};
      end
   end

   // ==========================================================
   // set beats clear so an event during a read is kept
   always @(posedge clock) begin
      if (rst) begin
         flags_r <= `DCS_STS_RST;
      end else begin
         flags_r <= (flags_r & ~clr_v) | set_v;
      end
   end

endmodule

// ==== verilog/dcs_top.v ====
// serial diagnostic setup and fault status message block
`include "dcs_defs.vh"

module dcs_top (
   input  wire        clock,
   input  wire        rst,
   input  wire        sck,
   input  wire        cs_n,
   input  wire        si,
   output reg         so_r,
   output reg         so_oe_n_r,
   input  wire [7:0]  ground_short_evt,
   input  wire [7:0]  gate_off_test_evt,
   input  wire [7:0]  battery_short_evt,
   input  wire [7:0]  battery_short_test_evt,
   input  wire [7:0]  open_load_gate_off_evt,
   input  wire [7:0]  open_load_gate_on_evt,
   input  wire [7:0]  channel_fault_pin_mask,
   output wire [15:0] battery_short_level,
   output wire [31:0] battery_short_retry_interval,
   output reg  [63:0] retry_periods_r,
   output reg         fault_out_r,
   output reg         frame_error_r
);

   // ==========================================================
   // state codes
   localparam ST_IDLE  = 3'h1;
   localparam ST_SHIFT = 3'h2;
   localparam ST_DONE  = 3'h4;

   // ==========================================================
   // declarations
   wire [2:0]  pins_s;
   wire        sck_s;
   wire        cs_n_s;
   wire        si_s;
   reg         sck_d_r;
   reg         cs_n_d_r;
   wire        sck_rise;
   wire        sck_fall;
   wire        cs_fall;
   wire        cs_rise;
   reg  [2:0]  state_r;
   reg  [5:0]  cnt_r;
   reg  [31:0] rx_r;
   reg  [31:0] tx_r;
   reg  [31:0] resp_r;
   reg  [47:0] cfg_r;
   wire [47:0] flags;
   wire [6:0]  rx_id;
   wire        rx_wr;
   wire        frame_ok;
   wire        sts_sel;
   wire        clear_low;
   wire        clear_high;
   reg  [7:0]  chan_fault;
   integer     i;
   integer     j;

   // ==========================================================
   // field group of one four-channel word
   // lowest channel lands in the top six bits
   function [23:0] grp_pack;
      input [47:0] v;
      input        grp;
      integer      k;
      integer      ch;
      begin
         grp_pack = 24'h000000;
         for (k = 0; k < 4; k = k + 1) begin
            ch = 4 * grp + k;
            grp_pack[23 - 6 * k -: 6] = v[6 * ch +: 6];
         end
      end
   endfunction

   // ==========================================================
   // write one four-channel word into the setup store
   function [47:0] cfg_put;
      input [47:0] cur;
      input        grp;
      input [23:0] w;
      integer      k;
      integer      ch;
      begin
         cfg_put = cur;
         for (k = 0; k < 4; k = k + 1) begin
            ch = 4 * grp + k;
            cfg_put[6 * ch +: 6] = w[23 - 6 * k -: 6];
         end
      end
   endfunction

   // ==========================================================
   // pin synchronisers; link clock is sampled, not used as a clock
   dcs_sync u_sync (
      .clock (clock),
      .rst   (rst),
      .d     ({sck, cs_n, si}),
      .q     (pins_s)
   );

   assign sck_s  = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign si_s   = pins_s[0];

   // ==========================================================
   // edge detection on the synchronised copies only
   always @(posedge clock) begin
      if (rst) begin
         sck_d_r  <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         sck_d_r  <= sck_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   assign sck_rise = sck_s & ~sck_d_r;
   assign sck_fall = ~sck_s & sck_d_r;
   assign cs_fall  = ~cs_n_s & cs_n_d_r;
   assign cs_rise  = cs_n_s & ~cs_n_d_r;

   // ==========================================================
   // decode of a finished frame
   assign rx_id    = rx_r[`DCS_ID_HI:`DCS_ID_LO];
   assign rx_wr    = rx_r[`DCS_RW_BIT];
   assign frame_ok = (cnt_r == `DCS_FRAME_BITS);

   // the status words are picked by two selectors
   assign sts_sel    = (rx_id == `DCS_ID_STS_LO) | (rx_id == `DCS_ID_STS_HI);
   // reading a status word clears the flags it reported
   // selector bit 0 tells the lower status group from the upper one
   assign clear_low  = (state_r == ST_DONE) & frame_ok & sts_sel & ~rx_id[0];
   assign clear_high = (state_r == ST_DONE) & frame_ok & sts_sel & rx_id[0];

   // ==========================================================
   // sticky fault and test-done flags
   dcs_status u_status (
      .clock                  (clock),
      .rst                    (rst),
      .ground_short_evt       (ground_short_evt),
      .gate_off_test_evt      (gate_off_test_evt),
      .battery_short_evt      (battery_short_evt),
      .battery_short_test_evt (battery_short_test_evt),
      .open_load_gate_off_evt (open_load_gate_off_evt),
      .open_load_gate_on_evt  (open_load_gate_on_evt),
      .clear_low              (clear_low),
      .clear_high             (clear_high),
      .flags_r                (flags)
   );

   // ==========================================================
   // frame sequencer: shift in on sck rise, shift out on sck fall
   // the answer to a frame goes out during the next frame, so a
   // read costs two frames but the shifter never races the decode
   always @(posedge clock) begin
      if (rst) begin
         state_r       <= ST_IDLE;
         cnt_r         <= 6'h00;
         rx_r          <= 32'h00000000;
         tx_r          <= 32'h00000000;
         resp_r        <= 32'h00000000;
         cfg_r         <= `DCS_CFG_RST;
         so_r          <= 1'b0;
         so_oe_n_r     <= 1'b1;
         frame_error_r <= 1'b0;
      end else begin
         frame_error_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (cs_fall) begin
                  // first answer bit must be on the pin before any sck edge
                  cnt_r     <= 6'h00;
                  tx_r      <= resp_r;
                  so_r      <= resp_r[31];
                  so_oe_n_r <= 1'b0;
                  state_r   <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (cs_rise) begin
                  so_oe_n_r <= 1'b1;
                  so_r      <= 1'b0;
                  state_r   <= ST_DONE;
               end else if (sck_rise) begin
                  rx_r <= {rx_r[30:0], si_s};
                  // saturate so a long burst cannot wrap back to 32
                  if (cnt_r != 6'h3F) begin
                     cnt_r <= cnt_r + 6'h01;
                  end
               end else if (sck_fall) begin
                  tx_r <= {tx_r[30:0], 1'b0};
                  so_r <= tx_r[30];
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
               if (!frame_ok) begin
                  // wrong pulse count: drop the frame, keep old answer
                  frame_error_r <= 1'b1;
               end else begin
                  case (rx_id)
                     `DCS_ID_CFG_LO: begin
                        if (rx_wr) begin
                           cfg_r  <= cfg_put(cfg_r, 1'b0, rx_r[23:0]);
                           resp_r <= {1'b0, rx_id, rx_r[23:0]};
                        end else begin
                           resp_r <= {1'b0, rx_id, grp_pack(cfg_r, 1'b0)};
                        end
                     end
                     `DCS_ID_CFG_HI: begin
                        if (rx_wr) begin
                           cfg_r  <= cfg_put(cfg_r, 1'b1, rx_r[23:0]);
                           resp_r <= {1'b0, rx_id, rx_r[23:0]};
                        end else begin
                           resp_r <= {1'b0, rx_id, grp_pack(cfg_r, 1'b1)};
                        end
                     end
                     `DCS_ID_STS_LO: begin
                        // write bit ignored, setup store untouched
                        resp_r <= {1'b0, rx_id, grp_pack(flags, 1'b0)};
                     end
                     `DCS_ID_STS_HI: begin
                        resp_r <= {1'b0, rx_id, grp_pack(flags, 1'b1)};
                     end
                     default: begin
                        // other messages are served elsewhere; answer zero
                        resp_r <= 32'h00000000;
                     end
                  endcase
               end
            end
            default: begin
               state_r   <= ST_IDLE;
               so_oe_n_r <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // setup fields straight from the store to the detectors
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_out
         assign battery_short_level[2 * g +: 2]          = cfg_r[6 * g + 4 +: 2];
         assign battery_short_retry_interval[4 * g +: 4] = cfg_r[6 * g +: 4];
      end
   endgenerate

   // ==========================================================
   // retry interval in PWM periods, sixteen per field step
   // one cycle behind the store, harmless against PWM time scales
   always @(posedge clock) begin
      if (rst) begin
         retry_periods_r <= {8{`DCS_RETRY_RST, 4'h0}};
      end else begin
         for (i = 0; i < 8; i = i + 1) begin
            retry_periods_r[8 * i +: 8] <= {cfg_r[6 * i +: 4], 4'h0};
         end
      end
   end

   // ==========================================================
   // channel fault summary; tested flags are not faults
   always @* begin
      chan_fault = 8'h00;
      // own loop index: the clocked retry process already drives i
      for (j = 0; j < 8; j = j + 1) begin
         chan_fault[j] = flags[6 * j + `DCS_F_GND] | flags[6 * j + `DCS_F_BAT] |
                         flags[6 * j + `DCS_F_OLOF] | flags[6 * j + `DCS_F_OLON];
      end
   end

   // ==========================================================
   // fault pin follows masked sticky faults
   always @(posedge clock) begin
      if (rst) begin
         fault_out_r <= 1'b0;
      end else begin
         fault_out_r <= |(chan_fault & channel_fault_pin_mask);
      end
   end

endmodule

// ==== sim/dcs_host_model.sv ====
// host side serial master model for the diagnostic message block
module dcs_host_model (
   input  wire logic clock,
   input  wire logic so_r,
   input  wire logic so_oe_n_r,
   output logic      sck,
   output logic      cs_n,
   output logic      si
);
   timeunit 1ns;
   timeprecision 1ns;
   logic so_last;
   // a released line shows the inverse of its last level, never a kind constant
   wire  so_seen = so_oe_n_r ? ~so_last : so_r;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      so_last = 1'b0;
   end
   always @(posedge clock) begin
      if (!so_oe_n_r) so_last <= so_r;
   end
   // ==========================================
   // one frame: n pulses, sample on rise, change on fall, 160 ns period
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      @(negedge clock);
      cs_n = 1'b0;
      si = tx[31];
      repeat (5) @(negedge clock);
      for (int i = 0; i < n; i++) begin
         sck = 1'b1;
         rx = {rx[30:0], so_seen};
         repeat (4) @(negedge clock);
         sck = 1'b0;
         si = (i < 31) ? tx[30-i] : ~si;
         repeat (4) @(negedge clock);
      end
      cs_n = 1'b1;
      repeat (6) @(negedge clock);
   endtask
endmodule

// ==== sim/dcs_top_monitor.sv ====
// concurrent checks on the ports of the diagnostic message block
module dcs_top_monitor (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        cs_n,
   input wire logic        so_r,
   input wire logic        so_oe_n_r,
   input wire logic [7:0]  channel_fault_pin_mask,
   input wire logic [15:0] battery_short_level,
   input wire logic [31:0] battery_short_retry_interval,
   input wire logic [63:0] retry_periods_r,
   input wire logic        fault_out_r,
   input wire logic        frame_error_r
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ==========================================
   // expected period counts, sixteen times each retry field
   logic [63:0] per_exp;
   always_comb begin
      for (int c = 0; c < 8; c++) per_exp[8*c +: 8] = {battery_short_retry_interval[4*c +: 4], 4'h0};
   end
   a_per_scaled: assert property (retry_periods_r == $past(per_exp)) else $error("period mismatch");
   a_level_frame: assert property (!$stable(battery_short_level) |-> cs_n && so_oe_n_r)
      else $error("level moved in frame");
   a_retry_frame: assert property (!$stable(battery_short_retry_interval) |-> cs_n && so_oe_n_r)
      else $error("retry moved in frame");
   a_so_quiet: assert property (so_oe_n_r |-> !so_r) else $error("so active outside frame");
   a_oe_idle: assert property (cs_n [*5] |-> so_oe_n_r) else $error("so enabled while idle");
   a_oe_frame: assert property ($fell(cs_n) |-> ##[2:4] !so_oe_n_r) else $error("so not enabled");
   a_fault_mask: assert property (fault_out_r |-> $past(channel_fault_pin_mask) != 8'h00)
      else $error("fault pin without mask");
   a_err_pulse: assert property (frame_error_r |=> !frame_error_r) else $error("error held");
   a_err_after: assert property (frame_error_r |-> $past(cs_n, 2)) else $error("error inside frame");
endmodule
bind dcs_top dcs_top_monitor mon_u (.clock(clock), .rst(rst), .cs_n(cs_n), .so_r(so_r),
   .so_oe_n_r(so_oe_n_r), .channel_fault_pin_mask(channel_fault_pin_mask),
   .battery_short_level(battery_short_level), .battery_short_retry_interval(battery_short_retry_interval),
   .retry_periods_r(retry_periods_r), .fault_out_r(fault_out_r), .frame_error_r(frame_error_r));

// ==== sim/dcs_top_tb_top.sv ====
// self-checking bench for the diagnostic message block
module dcs_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  ev_gnd = 8'h00, ev_ot = 8'h00, ev_bat = 8'h00, ev_st = 8'h00, ev_of = 8'h00, ev_on = 8'h00;
   logic [7:0]  mask = 8'h00;
   logic        sck, cs_n, si, so_r, so_oe_n_r, fault_out_r, frame_error_r;
   logic [15:0] lvl;
   logic [31:0] rty;
   logic [63:0] per;
   int          mismatches = 0;
   int          total_checks = 0;
   int          err_seen = 0;
   always #10 clock = ~clock;
   dcs_host_model host_u (.clock(clock), .so_r(so_r), .so_oe_n_r(so_oe_n_r), .sck(sck), .cs_n(cs_n), .si(si));
   dcs_top dut_u (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so_r(so_r),
      .so_oe_n_r(so_oe_n_r), .ground_short_evt(ev_gnd), .gate_off_test_evt(ev_ot),
      .battery_short_evt(ev_bat), .battery_short_test_evt(ev_st), .open_load_gate_off_evt(ev_of),
      .open_load_gate_on_evt(ev_on), .channel_fault_pin_mask(mask), .battery_short_level(lvl),
      .battery_short_retry_interval(rty), .retry_periods_r(per), .fault_out_r(fault_out_r),
      .frame_error_r(frame_error_r));
   // error pulses last one cycle, so count them as they pass
   always @(posedge clock) begin
      if (frame_error_r === 1'b1) err_seen <= err_seen + 1;
   end
   // ==========================================
   // shared helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // answers come one frame late, so a harmless setup read fetches them
   task automatic ans(input logic [31:0] cmd, input logic [31:0] exp);
      logic [31:0] r;
      host_u.xfer(cmd, 32, r);
      host_u.xfer(32'h02000000, 32, r);
      chk(r, exp);
   endtask
   task automatic finish_test;
      $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
      if (mismatches == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      chk(lvl, 16'hFFFF);
      chk(rty, 32'hFFFFFFFF);
      chk(per, 64'hF0F0F0F0F0F0F0F0);
      ans(32'h02000000, 32'h02FFFFFF);
      ans(32'h03000000, 32'h03FFFFFF);
      ans(32'h04000000, 32'h04000000);
      ans(32'h05000000, 32'h05000000);
   endtask
   // every threshold code once, distinct retry on channels 0-3
   task automatic t_setup;
      ans(32'h820528F0, 32'h020528F0);
      chk(lvl, 16'hFFE4);
      chk(rty, 32'hFFFF0321);
      chk(per, 64'hF0F0F0F000302010);
      ans(32'h83000000, 32'h03000000);
      chk({lvl, rty}, {16'h00E4, 32'h00000321});
      ans(32'h02000000, 32'h020528F0);
   endtask
   task automatic t_status;
      @(negedge clock);
      ev_gnd = 8'h01; ev_ot = 8'h02; ev_bat = 8'h04; ev_st = 8'h08; ev_of = 8'h10; ev_on = 8'h20;
      @(negedge clock);
      ev_gnd = 8'h00; ev_ot = 8'h00; ev_bat = 8'h00; ev_st = 8'h00; ev_of = 8'h00; ev_on = 8'h00;
      mask = 8'h08;
      cyc(4);
      chk(fault_out_r, 1'b0);
      mask = 8'h01;
      cyc(4);
      chk(fault_out_r, 1'b1);
      mask = 8'h00;
      cyc(4);
      chk(fault_out_r, 1'b0);
      ans(32'h84FFFFFF, 32'h04810204);
      ans(32'h85000000, 32'h05081000);
      chk({lvl, rty}, {16'h00E4, 32'h00000321});
      ans(32'h04000000, 32'h04000000);
      ans(32'h05000000, 32'h05000000);
   endtask
   // short frame must be thrown away, unknown selector answers zero
   task automatic t_bad;
      logic [31:0] r;
      int e0;
      e0 = err_seen;
      host_u.xfer(32'h82FFFFFF, 31, r);
      cyc(10);
      chk(err_seen, e0 + 1);
      chk(lvl, 16'h00E4);
      ans(32'h06000000, 32'h00000000);
      ans(32'h87000000, 32'h00000000);
   endtask
   initial begin
      cyc(4);
      rst = 1'b0;
      cyc(2);
      t_reset();
      t_setup();
      t_status();
      t_bad();
      finish_test();
   end
   // watchdog: about thirty frames of ~270 cycles each, limit set near 20000 cycles
   initial begin
      #400000;
      mismatches++;
      finish_test();
   end
endmodule
